//--- aocp_params.svh
// register offsets, field positions, reset values and thresholds of the output cell port
`ifndef AOCP_PARAMS_SVH
`define AOCP_PARAMS_SVH
// register byte offsets (one aligned 32-bit word each)
`define AOCP_CFG_OFS 8'h00
`define AOCP_LEN_OFS 8'h04
`define AOCP_STAT_OFS 8'h08
// configuration register field positions
`define AOCP_CFG_ODD_BIT 0
`define AOCP_CFG_ALL16_BIT 1
`define AOCP_CFG_OCALOW_BIT 2
`define AOCP_CFG_ZEROLVL_BIT 3
// status register field positions
`define AOCP_STAT_QUEUED_LSB 0
`define AOCP_STAT_INCELL_BIT 3
`define AOCP_STAT_COUNT_LSB 8
// reset values: even parity, byte-split parity, active-high cell available, four-word level
`define AOCP_CFG_RST 4'h0
`define AOCP_LEN_RST 6'h1b
// cell available falls when this many entries of the current cell remain
`define AOCP_LVL_FOUR 6'h04
`define AOCP_LVL_ZERO 6'h00
// bus encodings
`define AOCP_HSIZE_WORD 3'h2
`define AOCP_BYTE_ZERO 8'h00
`define AOCP_WORD_ZERO 16'h0000
`endif

//--- aocp_pkg.sv
// types shared by the output cell port
`default_nettype none
package aocp_pkg;
   // software configuration bits
   typedef struct packed {
      logic zeroLevel;   // cell available falls at zero instead of four
      logic ocaLow;      // cell available active low
      logic parityAll16; // upper parity spans whole word
      logic oddParity;   // odd instead of even parity
   } aocp_cfg_s;

   // one stored bus entry
   typedef struct packed {
      logic first;       // first entry of a cell
      logic [15:0] data; // word, or octet in the low byte
   } aocp_entry_s;

   // link pin samplers, two stages each
   typedef struct packed {
      logic [1:0] clkSync;
      logic clkPrev;
      logic [1:0] renSync;
      logic renOld;
      logic [1:0] bus8Sync;
      logic [1:0] tsenSync;
   } aocp_pins_s;
endpackage : aocp_pkg
`default_nettype wire

//--- aocp_output_cell_port.sv
// output cell fifo read port with ahb-lite configuration registers
//
// Functional notes
// - outputs change, enable sampled, on read edge
// - byte select: 10-bit bus, else 19-bit
// - enable low on edge pops one word
// - enable high: no pop; float if tristating
// - tristate enable low: always drive outputs
// - data held zero when nothing transferred
// - byte mode uses only low eight bits
// - parity bits default per byte
// - option: upper parity over sixteen bits
// - register bit selects odd/even parity
// - start flag marks first cell word
// - cell available polarity programmable, default high
// - cell available while complete cell stored
// - falls at four or zero remaining
// - fifo buffers up to four cells
// - cells are 52-63 octets or 26-32 words
`timescale 1ns/1ps
`default_nettype none
`include "aocp_params.svh"

module aocp_output_cell_port
   import aocp_pkg::*;
#(
   parameter int CELLS = 4,         // cells the fifo holds
   parameter int MAX_CELL_LEN = 63, // longest cell in bus entries
   parameter int DEPTH = 252        // entries of storage
) (
   input wire logic clk,
   input wire logic rst_n,
   // ahb-lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // cell words from the cell processing side
   input wire logic cellWrValid,
   input wire logic [15:0] cellWrData,
   output logic cellWrReady,
   // link side pins
   input wire logic outputFifoReadClock,
   input wire logic outputReadEnable_n,
   input wire logic outputByteWidthSelect,
   input wire logic outputTristateEnable,
   output logic [15:0] outputCellData,
   output logic outputCellDataOe,
   output logic [1:0] outputParity,
   output logic outputParityOe,
   output logic outputStartOfCell,
   output logic outputStartOfCellOe,
   output logic outputCellAvailable
);

   // pointer and occupancy widths follow the storage depth
   localparam int PW = $clog2(DEPTH);     // pointer width
   localparam int CW = $clog2(DEPTH + 1); // occupancy width

   // refuse sizes the logic cannot serve
   if (DEPTH < CELLS * MAX_CELL_LEN || MAX_CELL_LEN > 63 || CELLS > 7 || CW > 8) begin : gSizeCheck
      $error("aocp_output_cell_port: unsupported fifo sizing");
   end

   // whole state of the port
   typedef struct packed {
      aocp_pins_s pins;              // link pin samplers
      aocp_cfg_s cfg;                // configuration register
      logic [5:0] cellLen;           // entries per cell
      logic [PW-1:0] wrPtr;          // write pointer
      logic [PW-1:0] rdPtr;          // read pointer
      logic [CW-1:0] count;          // stored entries
      logic [5:0] wrIdx;             // entry index in cell being written
      logic [2:0] cellsQueued;       // complete cells not yet started
      logic inCell;                  // a cell is being read out
      logic [5:0] remain;            // entries left of current cell
      logic wrReady;                 // room for one more entry
      logic [15:0] data;             // data pins
      logic [1:0] parity;            // parity pins
      logic soc;                     // start of cell pin
      logic pinOe;                   // drive enable of data, parity, start
      logic output_cell_available;                     // cell available pin
      logic ahbWr;                   // pending write data phase
      logic [7:0] ahbAddr;           // address of pending write
      logic [31:0] rdData;           // read data register
      logic readyOut;                // bus ready
      aocp_entry_s [DEPTH-1:0] mem;  // entry storage
   } aocp_state_s;

   aocp_state_s s_q; // registered state
   aocp_state_s s_d; // next state

   // parity of one byte, flipped for odd parity
   function automatic logic byteParity(input logic [7:0] b, input logic odd);
      byteParity = (^b) ^ odd;
   endfunction : byteParity

   // advance a pointer with wrap at the storage end
   function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
      nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : nextPtr

   // readable view of a register, zero outside the map
   function automatic logic [31:0] regRead(input logic [7:0] a, input aocp_state_s st);
      logic [31:0] r;
      r = '0;
      if (a == `AOCP_CFG_OFS) begin
         r[3:0] = st.cfg;
      end else if (a == `AOCP_LEN_OFS) begin
         r[5:0] = st.cellLen;
      end else if (a == `AOCP_STAT_OFS) begin
         r[`AOCP_STAT_QUEUED_LSB +: 3] = st.cellsQueued;
         r[`AOCP_STAT_INCELL_BIT] = st.inCell;
         r[`AOCP_STAT_COUNT_LSB +: 8] = 8'(st.count);
      end
      regRead = r;
   endfunction : regRead

   // combinational helpers shared with the checks
   logic rdEdge;          // rising edge of read clock seen
   logic renLow;          // read enable as sampled just before that edge
   logic byteMode;        // synchronised byte width select
   logic tsen;            // synchronised tristate enable
   logic popFire;         // word popped on this edge
   aocp_entry_s popEntry; // entry at the read pointer
   logic pushFire;        // entry written this cycle
   logic ocaRaw;          // cell available before polarity

   // next-state logic
   always_comb begin
      logic [15:0] wrWord;
      logic [5:0] thr;
      logic [7:0] a;
      logic [2:0] cellsHeld; // cells queued plus the one being read
      s_d = s_q;
      wrWord = '0;
      thr = '0;
      a = '0;
      cellsHeld = '0;

      // two-stage samplers; the second stage is looked at, plus one further delayed copy of clock and enable
      s_d.pins.clkSync = {s_q.pins.clkSync[0], outputFifoReadClock};
      s_d.pins.clkPrev = s_q.pins.clkSync[1];
      s_d.pins.renSync = {s_q.pins.renSync[0], outputReadEnable_n};
      s_d.pins.renOld = s_q.pins.renSync[1];
      s_d.pins.bus8Sync = {s_q.pins.bus8Sync[0], outputByteWidthSelect};
      s_d.pins.tsenSync = {s_q.pins.tsenSync[0], outputTristateEnable};

      // enable is taken one cycle older than the clock, since the
      // reader moves it right after the edge it was set up for
      rdEdge = s_q.pins.clkSync[1] & ~s_q.pins.clkPrev;
      renLow = ~s_q.pins.renOld;
      byteMode = s_q.pins.bus8Sync[1];
      tsen = s_q.pins.tsenSync[1];

      // write side: one entry per accepted word
      pushFire = cellWrValid & s_q.wrReady;
      // octet mode keeps the upper lane empty
      wrWord = byteMode ? {`AOCP_BYTE_ZERO, cellWrData[7:0]} : cellWrData;
      if (pushFire) begin
         s_d.mem[s_q.wrPtr] = '{first: (s_q.wrIdx == '0), data: wrWord};
         s_d.wrPtr = nextPtr(s_q.wrPtr);
         // a cell counts once its last entry is in
         if (s_q.wrIdx == s_q.cellLen - 6'h01) begin
            s_d.wrIdx = '0;
            s_d.cellsQueued = s_q.cellsQueued + 3'h1;
         end else begin
            s_d.wrIdx = s_q.wrIdx + 6'h01;
         end
      end

      // read side: pop only from a complete cell
      popEntry = s_q.mem[s_q.rdPtr];
      popFire = rdEdge & renLow & (s_q.inCell | (s_q.cellsQueued != '0));
      if (popFire) begin
         s_d.rdPtr = nextPtr(s_q.rdPtr);
         // the first entry reloads the length, later ones count down
         if (popEntry.first) begin
            s_d.cellsQueued = s_d.cellsQueued - 3'h1;
            s_d.remain = s_q.cellLen - 6'h01;
         end else begin
            s_d.remain = s_q.remain - 6'h01;
         end
         s_d.inCell = (s_d.remain != '0);
      end

      // occupancy and write back-pressure; a push and a pop in one cycle both apply
      s_d.count = s_q.count + CW'(pushFire) - CW'(popFire);
      // capacity is counted in cells as well as entries: short cells leave
      // storage unused, but the queue counter can never wrap
      cellsHeld = s_d.cellsQueued + 3'(s_d.inCell);
      s_d.wrReady = (s_d.count < CW'(DEPTH)) && ((s_d.wrIdx != '0) || (cellsHeld < 3'(CELLS)));

      // cell available ahead of polarity
      thr = s_q.cfg.zeroLevel ? `AOCP_LVL_ZERO : `AOCP_LVL_FOUR;
      ocaRaw = (s_d.cellsQueued != '0) | (s_d.inCell & (s_d.remain > thr));

      // pins change only on the read clock edge
      if (rdEdge) begin
         if (popFire) begin
            s_d.data = popEntry.data;
            s_d.soc = popEntry.first;
         end else begin
            // no transfer: bus rests at zero
            s_d.data = `AOCP_WORD_ZERO;
            s_d.soc = 1'b0;
         end
         // float only when tristating and the reader is not reading
         s_d.pinOe = ~(tsen & ~renLow);
         s_d.parity[0] = byteParity(s_d.data[7:0], s_q.cfg.oddParity);
         if (byteMode) begin
            // single parity bit on the 10-bit bus
            s_d.parity[1] = 1'b0;
         end else if (s_q.cfg.parityAll16) begin
            s_d.parity[1] = (^s_d.data) ^ s_q.cfg.oddParity;
         end else begin
            s_d.parity[1] = byteParity(s_d.data[15:8], s_q.cfg.oddParity);
         end
         s_d.output_cell_available = ocaRaw ^ s_q.cfg.ocaLow;
      end

      // ahb data phase of a pending write
      s_d.ahbWr = 1'b0;
      if (s_q.ahbWr) begin
         if (s_q.ahbAddr == `AOCP_CFG_OFS) begin
            s_d.cfg = hwdata[3:0];
         end else if (s_q.ahbAddr == `AOCP_LEN_OFS) begin
            // changing this with cells stored corrupts framing
            s_d.cellLen = hwdata[5:0];
         end
      end

      // ahb address phase; reads see the write just completed
      if (hsel & htrans[1] & hready) begin
         a = haddr[7:0];
         // accesses above the small map read as zero and write nothing
         if (haddr[31:8] != '0) begin
            a = 8'hff;
         end
         s_d.ahbWr = hwrite & (hsize == `AOCP_HSIZE_WORD);
         s_d.ahbAddr = a;
         s_d.rdData = hwrite ? '0 : regRead(a, s_d);
      end
      s_d.readyOut = 1'b1;
   end

   // single state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         // enable samplers start at the idle high level, so release shows no read
         s_q.pins.renSync <= 2'h3;
         s_q.pins.renOld <= 1'b1;
         s_q.cfg <= `AOCP_CFG_RST;
         s_q.cellLen <= `AOCP_LEN_RST;
         s_q.wrReady <= 1'b1;
         s_q.pinOe <= 1'b1;
         s_q.readyOut <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // every output but hresp straight from the state register; hresp tied low
   assign hrdata = s_q.rdData;
   assign hreadyout = s_q.readyOut;
   assign hresp = 1'b0;
   assign cellWrReady = s_q.wrReady;
   assign outputCellData = s_q.data;
   // data, parity and start share one enable flop, so they float together
   assign outputCellDataOe = s_q.pinOe;
   assign outputParity = s_q.parity;
   assign outputParityOe = s_q.pinOe;
   assign outputStartOfCell = s_q.soc;
   assign outputStartOfCellOe = s_q.pinOe;
   assign outputCellAvailable = s_q.output_cell_available;

   // checks on the port behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // read clock edge with enable low or high
   sequence readEdgeLow;
      rdEdge && renLow;
   endsequence
   sequence readEdgeHigh;
      rdEdge && !renLow;
   endsequence
   sequence quietCycle;
      !rdEdge;
   endsequence

   popWord_a: assert property (popFire |=> s_q.data == $past(popEntry.data) && s_q.pinOe)
      else $error("popped word not presented");
   noReadFloat_a: assert property (readEdgeHigh ##0 tsen |=> !s_q.pinOe && $stable(s_q.rdPtr))
      else $error("idle read did not float or moved pointer");
   alwaysDriven_a: assert property (rdEdge && !tsen |=> s_q.pinOe)
      else $error("outputs not driven with tristate off");
   idleZero_a: assert property (rdEdge && !popFire |=> s_q.data == '0 && !s_q.soc)
      else $error("bus not zero without transfer");
   byteLane_a: assert property (rdEdge && byteMode |=> s_q.data[15:8] == '0 && !s_q.parity[1])
      else $error("upper lane used in byte mode");
   lowParity_a: assert property (rdEdge |=> s_q.parity[0] == ((^s_q.data[7:0]) ^ s_q.cfg.oddParity))
      else $error("lower parity wrong");
   wordParity_a: assert property (rdEdge && !byteMode && s_q.cfg.parityAll16 && $stable(s_q.cfg)
      |=> s_q.parity[1] == ((^s_q.data) ^ s_q.cfg.oddParity))
      else $error("sixteen bit parity wrong");
   startMark_a: assert property (popFire |=> s_q.soc == $past(popEntry.first))
      else $error("start of cell mismatch");
   pinsStill_a: assert property (quietCycle |=> $stable(s_q.data) && $stable(s_q.output_cell_available) && $stable(s_q.soc))
      else $error("pins moved off the read edge");
   availLevel_a: assert property (readEdgeLow or readEdgeHigh |=> s_q.output_cell_available == ($past(ocaRaw) ^ $past(s_q.cfg.ocaLow)))
      else $error("cell available polarity wrong");
   availQueued_a: assert property (rdEdge && s_d.cellsQueued != '0 |=> s_q.output_cell_available != s_q.cfg.ocaLow || $changed(s_q.cfg))
      else $error("cell available low with a cell queued");
   availFall_a: assert property (rdEdge && s_d.cellsQueued == '0 && s_d.inCell
      && s_d.remain <= `AOCP_LVL_FOUR && !s_q.cfg.zeroLevel |=> s_q.output_cell_available == s_q.cfg.ocaLow || $changed(s_q.cfg))
      else $error("cell available not dropped at four");
   fifoBound_a: assert property (s_q.count <= CW'(DEPTH) && s_q.cellsQueued <= 3'(CELLS))
      else $error("fifo over capacity");

   // first entry of a cell leaving the store
   sequence cellStartPop;
      popFire && popEntry.first;
   endsequence
   // later entry of a cell leaving the store
   sequence cellBodyPop;
      popFire && !popEntry.first;
   endsequence

   cellOpen_a: assert property (cellStartPop |=> s_q.remain == $past(s_q.cellLen) - 6'h01)
      else $error("cell start did not load its length");
   countDown_a: assert property (cellBodyPop |=> s_q.remain == $past(s_q.remain) - 6'h01)
      else $error("cell entries not counted down");
   // write side: never more cells than the fifo is sized for
   cellLimit_a: assert property (s_q.cellsQueued + 3'(s_q.inCell) <= 3'(CELLS))
      else $error("more cells held than the fifo serves");
   fifthCell_a: assert property (s_q.wrIdx == '0 && s_q.cellsQueued + 3'(s_q.inCell) == 3'(CELLS)
      |-> !s_q.wrReady)
      else $error("ready offered beyond cell capacity");

endmodule : aocp_output_cell_port

`default_nettype wire

//--- aocp_cell_reader.sv
// reader model: the switch core pulling cell entries off the link
`timescale 1ns/1ps
`default_nettype none

module aocp_cell_reader (
   output logic outputFifoReadClock,
   output logic outputReadEnable_n,
   input wire logic [15:0] outputCellData,
   input wire logic [1:0] outputParity,
   input wire logic outputStartOfCell,
   input wire logic outputCellDataOe,
   input wire logic outputCellAvailable
);
   logic [20:0] seenQ[$]; // {available, drive, start, parity, data} per read edge

   // read clock parked low outside frames, enable idle high
   initial begin
      outputFifoReadClock = 1'b0;
      outputReadEnable_n = 1'b1;
   end

   // snapshot of the pins just before the next read edge, after they settled
   task automatic grab();
      // a floated bus holds no value: show the inverse so a sample of it is noticed
      seenQ.push_back({outputCellAvailable, outputCellDataOe, outputStartOfCell, outputParity,
         outputCellDataOe ? outputCellData : ~outputCellData});
   endtask : grab

   // n periods of 200 ns: 5 MHz, far below the ceiling, every entry drained promptly
   task automatic readCycles(input int n, input logic enN);
      seenQ.delete();
      #12; // link edges kept clear of the system clock edges
      for (int i = 0; i < n; i++) begin
         outputReadEnable_n = enN; // moved as the clock falls, clear of the sampling edge
         #95;
         if (i > 0) begin
            grab();
         end
         #5 outputFifoReadClock = 1'b1;
         #100 outputFifoReadClock = 1'b0;
      end
      #95;
      grab();
      outputReadEnable_n = 1'b1; // no reads between frames
   endtask : readCycles
endmodule : aocp_cell_reader
`default_nettype wire

//--- tb_aocp_output_cell_port.sv
// self-checking bench for the output cell port
`timescale 1ns/1ps
`default_nettype none
`include "aocp_params.svh"

module tb_aocp_output_cell_port;
   import aocp_pkg::*;
   localparam int LEN = 27;  // default cell length, word mode
   localparam int LEN8 = 52; // shortest byte-mode cell
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, cellWrValid, cellWrReady, byteSel, tsen;
   logic [31:0] haddr, hwdata, hrdata, busData;
   logic [1:0] htrans, parity;
   logic [2:0] hsize;
   logic [15:0] cellWrData, data;
   logic rclk, renN, dataOe, parityOe, soc, socOe, output_cell_available;
   wire logic hready = hreadyout; // single slave: its ready is the bus ready
   int miscompares = 0;
   int samplesChecked = 0;

   aocp_output_cell_port dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cellWrValid(cellWrValid), .cellWrData(cellWrData),
      .cellWrReady(cellWrReady), .outputFifoReadClock(rclk), .outputReadEnable_n(renN),
      .outputByteWidthSelect(byteSel), .outputTristateEnable(tsen), .outputCellData(data),
      .outputCellDataOe(dataOe), .outputParity(parity), .outputParityOe(parityOe),
      .outputStartOfCell(soc), .outputStartOfCellOe(socOe), .outputCellAvailable(output_cell_available));
   aocp_cell_reader rd (.outputFifoReadClock(rclk), .outputReadEnable_n(renN), .outputCellData(data),
      .outputParity(parity), .outputStartOfCell(soc), .outputCellDataOe(dataOe),
      .outputCellAvailable(output_cell_available));

   // 40 MHz system clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // single comparison point, counts everything
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         miscompares++;
      end
   endtask : check

   // verdict and end of run
   task automatic complete_run();
      $display("miscompares %0d samplesChecked %0d", miscompares, samplesChecked);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   // bounded wait for a ready (0: bus, 1: cell write) sampled high at a rising edge
   task automatic waitFor(input int which);
      logic r;
      int n;
      n = 0;
      do begin
         @(negedge clk);
         r = which ? cellWrReady : hreadyout;
         busData = hrdata; // data phase value, taken at the closing edge
         @(posedge clk);
         n++;
      end while (r !== 1'b1 && n < 50);
      if (r !== 1'b1) begin
         miscompares++; // a hang counts as a mismatch
         complete_run();
      end
   endtask : waitFor

   // one single word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
      {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'b10, addr, wr, `AOCP_HSIZE_WORD};
      waitFor(0);
      {hsel, htrans} <= {1'b0, 2'b00};
      hwdata <= wdata;
      waitFor(0);
   endtask : ahb

   task automatic regCheck(input logic [31:0] addr, input logic [31:0] exp);
      ahb(1'b0, addr, 32'h0);
      check("register", busData, exp);
      check("response", hresp, 1'b0);
   endtask : regCheck

   // entry pattern; upper byte is junk in byte mode and must never reach the pins
   function automatic logic [15:0] pat(input int i);
      return 16'(i * 16'h0103 + 16'h5a01);
   endfunction : pat

   task automatic pushCells(input int n);
      for (int i = 0; i < n; i++) begin
         cellWrValid <= 1'b1;
         cellWrData <= pat(i);
         waitFor(1);
      end
      cellWrValid <= 1'b0;
   endtask : pushCells

   // drain whole cells and judge every entry, flag and parity
   task automatic readAndCheck(input int cells, input int len, input logic byteMode, input aocp_cfg_s cfg);
      logic [15:0] d;
      logic [1:0] p;
      logic [20:0] s;
      int lvl;
      lvl = cfg.zeroLevel ? 0 : 4;
      rd.readCycles(cells * len, 1'b0);
      check("entries", rd.seenQ.size(), cells * len);
      for (int k = 0; k < rd.seenQ.size(); k++) begin
         s = rd.seenQ[k];
         d = pat(k);
         d = byteMode ? {8'h00, d[7:0]} : d;
         p[0] = cfg.oddParity ^ (^d[7:0]);
         p[1] = byteMode ? 1'b0 : cfg.oddParity ^ (cfg.parityAll16 ? ^d : ^d[15:8]);
         check("data", s[15:0], d);
         check("parity", s[17:16], p);
         check("start", s[18], k % len == 0);
         check("drive", s[19], 1'b1);
         check("available", s[20], cfg.ocaLow ^ (cells * len - k - 1 > lvl));
      end
      @(posedge clk);
   endtask : readAndCheck

   // idle frames: enable high (or low with nothing stored), pins float or sit at zero
   task automatic idleCheck(input logic t, input logic enN);
      tsen <= t;
      repeat (4) @(posedge clk);
      rd.readCycles(2, enN);
      foreach (rd.seenQ[k]) begin
         check("idle drive", rd.seenQ[k][19], !t);
         // floated pins read back inverted in the reader model
         check("idle data", rd.seenQ[k][15:0], t ? 16'hffff : 16'h0000);
         check("idle available", rd.seenQ[k][20], 1'b0);
      end
      check("parity drive", parityOe, !t);
      check("start drive", socOe, !t);
      @(posedge clk);
   endtask : idleCheck

   // reset in mid run: pins and configuration return to their defaults
   task automatic resetCheck();
      ahb(1'b1, `AOCP_CFG_OFS, 32'h0f);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("reset data", data, 16'h0000);
      check("reset available", output_cell_available, 1'b0);
      rst_n <= 1'b1;
      @(posedge clk);
      regCheck(`AOCP_CFG_OFS, 32'h0);
      regCheck(`AOCP_LEN_OFS, 32'h1b);
      regCheck(`AOCP_STAT_OFS, 32'h0);
   endtask : resetCheck

   // main sequence
   initial begin
      {rst_n, hsel, htrans, haddr, hwrite, hsize, hwdata} = '0;
      {cellWrValid, cellWrData, byteSel, tsen} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      regCheck(`AOCP_CFG_OFS, 32'h0);
      regCheck(`AOCP_LEN_OFS, 32'h1b);
      regCheck(32'h0c, 32'h0);
      ahb(1'b1, `AOCP_STAT_OFS, 32'hff);
      regCheck(`AOCP_STAT_OFS, 32'h0);
      idleCheck(1'b1, 1'b1);
      idleCheck(1'b0, 1'b1);
      idleCheck(1'b0, 1'b0);
      // four cells stored at once, then drained back to back
      pushCells(4 * LEN);
      regCheck(`AOCP_STAT_OFS, 32'h6c04);
      readAndCheck(4, LEN, 1'b0, aocp_cfg_s'(4'h0));
      // odd parity, whole-word upper parity, active-low flag, zero level, tristating on
      ahb(1'b1, `AOCP_CFG_OFS, 32'h0f);
      regCheck(`AOCP_CFG_OFS, 32'h0f);
      regCheck(32'h100, 32'h0); // upper address bits keep this off the map
      tsen <= 1'b1;
      pushCells(LEN);
      readAndCheck(1, LEN, 1'b0, aocp_cfg_s'(4'hf));
      // byte-wide bus with the shortest octet cell
      ahb(1'b1, `AOCP_CFG_OFS, 32'h0);
      ahb(1'b1, `AOCP_LEN_OFS, LEN8);
      byteSel <= 1'b1;
      repeat (4) @(posedge clk); // width select settles through its samplers before any entry
      pushCells(LEN8);
      readAndCheck(1, LEN8, 1'b1, aocp_cfg_s'(4'h0));
      resetCheck();
      complete_run();
   end
endmodule : tb_aocp_output_cell_port
`default_nettype wire
